// *** adcsc_ctrl.sv ***
// What this block does
// R1 - Single-output pseudo mode: only out_a, b tristated
// R2 - Command mux bits steer the pseudo-differential multiplexer
// R3 - Host avoids pseudo mux in automatic modes
// R4 - Page 01 action 001 arms DAC write
// R5 - Write access: two zeros then 10-bit value
// R6 - Page 01 action 011 arms DAC read
// R7 - Read access sends 0000, DAC value, 00
// R8 - Read access ignores input; out_b keeps data
// R9 - DAC level resets to all ones
// R10 - Power-down starts at twelfth clock of access
// R11 - Power-down ends only by clearing enable
// R12 - Command register untouched by power-down
// R13 - Deep or nap entry aborts conversion
// R14 - Deep wake takes one microsecond
// R15 - Nap enters anytime; wakes after three clocks
// R16 - Auto-nap sleeps after conversion, trigger wakes
// R17 - Action 101 resets whole device at clock twelve
// R18 - Interface ready twenty nanoseconds after reset
// R19 - Page 01 features, 00/11 pairs, 10 reserved
// R20 - Features take effect at twelfth clock
// R21 - Other action codes do nothing
// R22 - Host sends command MSB first, stable
`timescale 1ns/10ps
`default_nettype none

module adcsc_ctrl (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Host pins
	input wire logic read_strobe,
	input wire logic conv_trigger,
	input wire logic serial_cmd_in,
	input wire logic channel_auto_select_pin,
	input wire logic single_output_pin,
	output logic serial_out_a,
	output logic serial_out_b,
	output logic serial_out_b_oe,
	// Converter core
	input wire logic [11:0] adc_result_a,
	input wire logic [11:0] adc_result_b,
	output logic conv_busy,
	output logic conv_abort,
	output logic [1:0] mux_select,
	output logic pair_select,
	output logic [9:0] reference_dac_level,
	output logic ref_power_down,
	output logic special_read,
	// Power control
	output logic analog_off,
	output logic bias_off,
	output logic powered_up
);

	// Action decode for the DAC arming path; soft reset checks the action code alone
	function automatic logic is_act(input adcsc_pkg::adcsc_cmd_t w, input logic [2:0] code);
		is_act = (w.feature_page_select == adcsc_pkg::PAGE_FEAT) && (w.action_code == code);
	endfunction : is_act

	adcsc_pkg::adcsc_cmd_t cmd_reg; // Serial command register
	adcsc_pkg::adcsc_cmd_t word_in; // Word complete at clock twelve
	adcsc_pkg::adcsc_pwr_t pwr_reg; // Power state
	logic [4:0] acc_cnt_reg; // Access clock count, zero when idle
	logic [10:0] sh_in_reg; // Incoming command bits
	logic [15:0] sh_a_reg; // Outgoing frame on out_a
	logic [15:0] sh_b_reg; // Outgoing frame on out_b
	logic dac_wr_arm_reg; // Next access carries DAC value
	logic dac_rd_arm_reg; // Next access returns DAC value
	logic rd_access_reg; // Current access is a DAC read
	logic wr_access_reg; // Current access is a DAC write
	logic soft_rst_reg; // One-cycle internal reset
	logic [1:0] hold_reg; // Interface holdoff after soft reset
	logic [4:0] conv_cnt_reg; // Conversion clock count
	logic [4:0] wake_cnt_reg; // Wake-up countdown
	logic wake_conv_reg; // Start conversion once awake
	logic [11:0] res_a_reg; // Latched channel A result
	logic [11:0] res_b_reg; // Latched channel B result
	logic alt_b_reg; // Single-output mode sends B next
	logic auto_pair_reg; // Pair chosen by automatic cycling
	logic apply; // Twelfth clock of an access
	logic strobe_ok; // Strobe accepted
	logic conv_end; // Last clock of a conversion
	logic conv_start; // Conversion begins
	logic sleep_hit; // Deep or nap entry this cycle

	// Combinational decode of the access and conversion events
	always_comb begin
		word_in = adcsc_pkg::adcsc_cmd_t'({sh_in_reg, serial_cmd_in}); // [R22]
		apply = (acc_cnt_reg == 5'(adcsc_pkg::APPLY_CNT)); // [R20]
		strobe_ok = read_strobe && (acc_cnt_reg == 5'h00) && (hold_reg == 2'h0); // [R18]
		conv_end = conv_busy && (conv_cnt_reg == 5'(adcsc_pkg::CONV_CYC));
		conv_start = (conv_trigger && !conv_busy && (pwr_reg == adcsc_pkg::PWR_RUN))
			|| (wake_conv_reg && (pwr_reg == adcsc_pkg::PWR_WAKE) && (wake_cnt_reg == 5'h01));
		sleep_hit = (pwr_reg != adcsc_pkg::PWR_DEEP) && (pwr_reg != adcsc_pkg::PWR_NAP)
			&& (cmd_reg.deep_sleep_enable || cmd_reg.nap_enable);
	end

	// Soft reset pulse and interface holdoff
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_reg <= 1'b0;
			hold_reg <= 2'h0;
		end else if (clk_en) begin
			if (apply && !wr_access_reg && !rd_access_reg
				&& (word_in.action_code == adcsc_pkg::ACT_RESET)) begin
				soft_rst_reg <= 1'b1; // [R17]
			end else begin
				soft_rst_reg <= 1'b0;
			end
			if (soft_rst_reg) begin
				hold_reg <= 2'(adcsc_pkg::RST_READY_CYC); // [R18]
			end else if (hold_reg != 2'h0) begin
				hold_reg <= hold_reg - 2'h1;
			end
		end
	end

	// Access clock counter and command shift-in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_cnt_reg <= 5'h00;
			sh_in_reg <= 11'h000;
		end else if (clk_en) begin
			if (soft_rst_reg) begin
				acc_cnt_reg <= 5'h00; // [R17]
				sh_in_reg <= 11'h000;
			end else begin
				if (strobe_ok) begin
					acc_cnt_reg <= 5'h01;
				end else if (acc_cnt_reg == 5'(adcsc_pkg::FRAME_BITS)) begin
					acc_cnt_reg <= 5'h00;
				end else if (acc_cnt_reg != 5'h00) begin
					acc_cnt_reg <= acc_cnt_reg + 5'h01;
				end
				if ((acc_cnt_reg != 5'h00) && (acc_cnt_reg < 5'(adcsc_pkg::APPLY_CNT))) begin
					sh_in_reg <= {sh_in_reg[9:0], serial_cmd_in}; // [R22]
				end
			end
		end
	end

	// Command register, written at clock twelve of a plain access and cleared by soft reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_reg <= adcsc_pkg::CMD_RESET;
		end else if (clk_en) begin
			if (soft_rst_reg) begin
				cmd_reg <= adcsc_pkg::CMD_RESET; // [R17]
			end else if (apply && !wr_access_reg && !rd_access_reg) begin // [R5] [R8]
				// Power-down states never touch this register
				cmd_reg.mux_channel_select <= word_in.mux_channel_select; // [R2] [R12]
				cmd_reg.feature_page_select <= word_in.feature_page_select;
				cmd_reg.action_code <= word_in.action_code;
				if (word_in.feature_page_select == adcsc_pkg::PAGE_FEAT) begin
					cmd_reg.deep_sleep_enable <= word_in.deep_sleep_enable; // [R10] [R11]
					cmd_reg.nap_enable <= word_in.nap_enable; // [R19]
					cmd_reg.auto_sleep_enable <= word_in.auto_sleep_enable;
					cmd_reg.ref_power_down <= word_in.ref_power_down;
					cmd_reg.special_read <= word_in.special_read;
				end
			end
		end
	end

	// DAC write/read arming, one-access flags and DAC register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_wr_arm_reg <= 1'b0;
			dac_rd_arm_reg <= 1'b0;
			wr_access_reg <= 1'b0;
			rd_access_reg <= 1'b0;
			reference_dac_level <= adcsc_pkg::DAC_RESET; // [R9]
		end else if (clk_en) begin
			if (soft_rst_reg) begin
				dac_wr_arm_reg <= 1'b0;
				dac_rd_arm_reg <= 1'b0;
				wr_access_reg <= 1'b0;
				rd_access_reg <= 1'b0;
				reference_dac_level <= adcsc_pkg::DAC_RESET; // [R9]
			end else if (strobe_ok) begin
				// Armed flags become the kind of the new access
				wr_access_reg <= dac_wr_arm_reg;
				rd_access_reg <= dac_rd_arm_reg;
				dac_wr_arm_reg <= 1'b0;
				dac_rd_arm_reg <= 1'b0;
			end else if (apply) begin
				if (wr_access_reg) begin
					reference_dac_level <= word_in[9:0]; // [R5]
				end else if (!rd_access_reg) begin
					dac_wr_arm_reg <= is_act(word_in, adcsc_pkg::ACT_DAC_WR); // [R4] [R21]
					dac_rd_arm_reg <= is_act(word_in, adcsc_pkg::ACT_DAC_RD); // [R6] [R21]
				end
				wr_access_reg <= 1'b0;
				rd_access_reg <= 1'b0; // [R8]
			end
		end
	end

	// Output frames, loaded on the strobe and shifted MSB first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_a_reg <= 16'h0000;
			sh_b_reg <= 16'h0000;
			alt_b_reg <= 1'b0;
			serial_out_b_oe <= 1'b0;
		end else if (clk_en) begin
			serial_out_b_oe <= !single_output_pin; // [R1]
			if (soft_rst_reg) begin
				sh_a_reg <= 16'h0000;
				sh_b_reg <= 16'h0000;
				alt_b_reg <= 1'b0;
			end else if (strobe_ok) begin
				sh_b_reg <= {2'h0, res_b_reg, 2'h0}; // [R8]
				if (dac_rd_arm_reg) begin
					sh_a_reg <= {4'h0, reference_dac_level, 2'h0}; // [R7]
				end else if (single_output_pin) begin
					// Both results leave on out_a, one per access
					sh_a_reg <= {1'b0, alt_b_reg, (alt_b_reg ? res_b_reg : res_a_reg), 2'h0}; // [R1]
					alt_b_reg <= !alt_b_reg;
				end else begin
					sh_a_reg <= {2'h0, res_a_reg, 2'h0};
				end
			end else if (acc_cnt_reg != 5'h00) begin
				sh_a_reg <= {sh_a_reg[14:0], 1'b0};
				sh_b_reg <= {sh_b_reg[14:0], 1'b0};
			end
		end
	end

	assign serial_out_a = sh_a_reg[15];
	assign serial_out_b = sh_b_reg[15];

	// Conversion sequencing and result capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_busy <= 1'b0;
			conv_cnt_reg <= 5'h00;
			conv_abort <= 1'b0;
			res_a_reg <= 12'h000;
			res_b_reg <= 12'h000;
			auto_pair_reg <= 1'b0;
		end else if (clk_en) begin
			conv_abort <= 1'b0;
			if (soft_rst_reg) begin
				conv_busy <= 1'b0;
				conv_cnt_reg <= 5'h00;
				res_a_reg <= 12'h000;
				res_b_reg <= 12'h000;
				auto_pair_reg <= 1'b0;
			end else if (sleep_hit) begin
				// Entering deep or nap kills the running conversion
				conv_abort <= conv_busy; // [R13] [R15]
				conv_busy <= 1'b0;
				conv_cnt_reg <= 5'h00;
			end else if (conv_start) begin
				conv_busy <= 1'b1;
				conv_cnt_reg <= 5'h01;
			end else if (conv_end) begin
				conv_busy <= 1'b0;
				conv_cnt_reg <= 5'h00;
				res_a_reg <= adc_result_a;
				res_b_reg <= adc_result_b;
				if (channel_auto_select_pin) begin
					auto_pair_reg <= !auto_pair_reg;
				end
			end else if (conv_busy) begin
				conv_cnt_reg <= conv_cnt_reg + 5'h01;
			end
		end
	end

	// Power state machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg <= adcsc_pkg::PWR_RUN;
			wake_cnt_reg <= 5'h00;
			wake_conv_reg <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst_reg) begin
				pwr_reg <= adcsc_pkg::PWR_RUN;
				wake_cnt_reg <= 5'h00;
				wake_conv_reg <= 1'b0;
			end else begin
				case (pwr_reg)
					adcsc_pkg::PWR_RUN, adcsc_pkg::PWR_WAKE: begin
						if (cmd_reg.deep_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_DEEP; // [R10]
							wake_conv_reg <= 1'b0;
						end else if (cmd_reg.nap_enable) begin
							pwr_reg <= adcsc_pkg::PWR_NAP; // [R10] [R15]
							wake_conv_reg <= 1'b0;
						end else if (pwr_reg == adcsc_pkg::PWR_WAKE) begin
							if (wake_cnt_reg == 5'h01) begin
								pwr_reg <= adcsc_pkg::PWR_RUN;
								wake_conv_reg <= 1'b0;
							end
							wake_cnt_reg <= wake_cnt_reg - 5'h01;
						end else if (conv_end && cmd_reg.auto_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_ANAP; // [R16]
						end
					end
					adcsc_pkg::PWR_DEEP: begin
						if (!cmd_reg.deep_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_WAKE; // [R11] [R14]
							wake_cnt_reg <= 5'(adcsc_pkg::DEEP_WAKE_CYC);
						end
					end
					adcsc_pkg::PWR_NAP: begin
						if (cmd_reg.deep_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_DEEP;
						end else if (!cmd_reg.nap_enable) begin
							pwr_reg <= adcsc_pkg::PWR_WAKE; // [R11] [R15]
							wake_cnt_reg <= 5'(adcsc_pkg::NAP_WAKE_CYC);
						end
					end
					adcsc_pkg::PWR_ANAP: begin
						if (cmd_reg.deep_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_DEEP;
						end else if (cmd_reg.nap_enable) begin
							pwr_reg <= adcsc_pkg::PWR_NAP;
						end else if (!cmd_reg.auto_sleep_enable) begin
							pwr_reg <= adcsc_pkg::PWR_RUN; // [R16]
						end else if (conv_trigger) begin
							// Trigger wakes and starts once awake
							pwr_reg <= adcsc_pkg::PWR_WAKE; // [R16]
							wake_cnt_reg <= 5'(adcsc_pkg::NAP_WAKE_CYC);
							wake_conv_reg <= 1'b1;
						end
					end
					default: begin
						pwr_reg <= adcsc_pkg::PWR_RUN;
					end
				endcase
			end
		end
	end

	// Analog control outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_off <= 1'b0;
			bias_off <= 1'b0;
			powered_up <= 1'b0;
			mux_select <= 2'h0;
			pair_select <= 1'b0;
			ref_power_down <= 1'b0;
			special_read <= 1'b0;
		end else if (clk_en) begin
			analog_off <= (pwr_reg == adcsc_pkg::PWR_DEEP); // [R14]
			bias_off <= (pwr_reg == adcsc_pkg::PWR_NAP) || (pwr_reg == adcsc_pkg::PWR_ANAP)
				|| (pwr_reg == adcsc_pkg::PWR_DEEP);
			powered_up <= (pwr_reg == adcsc_pkg::PWR_RUN) && !soft_rst_reg;
			mux_select <= cmd_reg.mux_channel_select; // [R2]
			ref_power_down <= cmd_reg.ref_power_down;
			special_read <= cmd_reg.special_read;
			if (channel_auto_select_pin) begin
				pair_select <= auto_pair_reg;
			end else if (cmd_reg.feature_page_select == adcsc_pkg::PAGE_PAIR1) begin
				pair_select <= 1'b1; // [R19]
			end else if (cmd_reg.feature_page_select == adcsc_pkg::PAGE_PAIR0) begin
				pair_select <= 1'b0; // [R19]
			end
		end
	end

endmodule : adcsc_ctrl

`default_nettype wire

// *** adcsc_pkg.sv ***
package adcsc_pkg;

	// Clock rate and timing figures
	localparam int CLK_PERIOD_NS = 50;
	localparam int DEEP_WAKE_NS = 1000;
	localparam int DEEP_WAKE_CYC = (DEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NAP_WAKE_CYC = 3;
	localparam int RST_READY_NS = 20;
	localparam int RST_READY_RAW = (RST_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_READY_CYC = (RST_READY_RAW < 1) ? 1 : RST_READY_RAW;
	localparam int CONV_CYC = 16;

	// Access framing
	localparam int CMD_BITS = 12;
	localparam int APPLY_CNT = 12;
	localparam int FRAME_BITS = 16;
	localparam int RES_BITS = 12;
	localparam int DAC_BITS = 10;

	// Reset values
	localparam logic [9:0] DAC_RESET = 10'h3ff;

	// Feature page codes
	localparam logic [1:0] PAGE_PAIR0 = 2'h0;
	localparam logic [1:0] PAGE_FEAT = 2'h1;
	localparam logic [1:0] PAGE_RSVD = 2'h2;
	localparam logic [1:0] PAGE_PAIR1 = 2'h3;

	// Action codes
	localparam logic [2:0] ACT_DAC_WR = 3'h1;
	localparam logic [2:0] ACT_DAC_RD = 3'h3;
	localparam logic [2:0] ACT_RESET = 3'h5;

	// Command word, first bit shifted in is the top bit
	typedef struct packed {
		logic [1:0] mux_channel_select;
		logic [1:0] feature_page_select;
		logic deep_sleep_enable;
		logic nap_enable;
		logic auto_sleep_enable;
		logic ref_power_down;
		logic special_read;
		logic [2:0] action_code;
	} adcsc_cmd_t;

	localparam adcsc_cmd_t CMD_RESET = 12'h000;

	// Power states
	typedef enum logic [4:0] {
		PWR_RUN = 5'h01,
		PWR_DEEP = 5'h02,
		PWR_NAP = 5'h04,
		PWR_ANAP = 5'h08,
		PWR_WAKE = 5'h10
	} adcsc_pwr_t;

endpackage : adcsc_pkg

// *** adcsc_ctrl_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module adcsc_ctrl_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched pins
	input wire logic single_output_pin,
	input wire logic conv_trigger,
	input wire logic serial_out_b_oe,
	input wire logic conv_busy,
	input wire logic conv_abort,
	input wire logic [9:0] reference_dac_level,
	input wire logic special_read,
	input wire logic analog_off,
	input wire logic bias_off,
	input wire logic powered_up
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Level comes out of reset at all ones
	property p_dac_rst;
		$rose(rst_n) |-> reference_dac_level == adcsc_pkg::DAC_RESET;
	endproperty
	a_dac_rst: assert property (p_dac_rst) else $error("dac level not all ones");
	// Single-output mode leaves line b undriven
	property p_b_off;
		single_output_pin && $past(single_output_pin) |-> !serial_out_b_oe;
	endproperty
	a_b_off: assert property (p_b_off) else $error("line b driven");
	// Dual-output mode drives line b
	property p_b_on;
		powered_up && $past(powered_up) && !$past(single_output_pin) |-> serial_out_b_oe;
	endproperty
	a_b_on: assert property (p_b_on) else $error("line b not driven");
	// Deep state switches off everything analog
	property p_deep;
		analog_off |-> bias_off && !powered_up;
	endproperty
	a_deep: assert property (p_deep) else $error("deep state incomplete");
	// Abort only kills a running conversion and enters power-down
	property p_abort;
		conv_abort |-> $past(conv_busy) ##[0:3] bias_off;
	endproperty
	a_abort: assert property (p_abort) else $error("abort without cause");
	// Abort is a single pulse
	property p_abort_pulse;
		conv_abort |=> !conv_abort;
	endproperty
	a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
	// Nap wake takes a few clocks only
	property p_nap_wake;
		$fell(bias_off) && !$past(analog_off) |-> ##[0:5] powered_up;
	endproperty
	a_nap_wake: assert property (p_nap_wake) else $error("nap wake late");
	// Deep wake waits about one microsecond
	property p_deep_wake;
		$fell(analog_off) |-> !powered_up [*8] ##[1:20] powered_up;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("deep wake timing");
	// Trigger wakes the auto-nap state
	property p_anap_wake;
		bias_off && !analog_off && conv_trigger |-> ##[1:6] powered_up;
	endproperty
	a_anap_wake: assert property (p_anap_wake) else $error("auto-nap wake late");
	// Settings survive any power-down
	property p_hold;
		bias_off && $past(bias_off) |-> $stable(reference_dac_level) && $stable(special_read);
	endproperty
	a_hold: assert property (p_hold) else $error("settings lost");
endmodule : adcsc_ctrl_checker

bind adcsc_ctrl adcsc_ctrl_checker i_adcsc_ctrl_checker (.clk, .rst_n, .single_output_pin,
	.conv_trigger, .serial_out_b_oe, .conv_busy, .conv_abort, .reference_dac_level,
	.special_read, .analog_off, .bias_off, .powered_up);
`default_nettype wire

// *** adcsc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module adcsc_host_model (
	// Clock
	input wire logic clk,
	// Bench side
	input wire logic start,
	input wire logic [11:0] word,
	output logic active,
	output logic [15:0] frame_a,
	output logic [15:0] frame_b,
	// Device side
	output logic read_strobe,
	output logic serial_cmd_in,
	input wire logic serial_out_a,
	input wire logic serial_out_b
);
	int step = -1; // Access phase, -1 when idle
	logic [11:0] sh = 12'h000; // Command bits still to send
	logic act_q = 1'b0; // Access in progress
	logic strobe_q = 1'b0; // Read strobe level
	logic cmd_q = 1'b0; // Command bit level

	// Each pin has a single driver
	assign active = act_q;
	assign read_strobe = strobe_q;
	assign serial_cmd_in = cmd_q;

	// Host pins move on the falling edge only
	always @(negedge clk) begin
		if (step < 0) begin
			// Idle line toggles so no stale bit looks like data
			cmd_q <= ~cmd_q;
			if (start) begin
				strobe_q <= 1'b1;
				sh <= word;
				act_q <= 1'b1;
				step <= 0;
			end
		end else begin
			strobe_q <= 1'b0;
			// Command leaves top bit first, one bit a cycle
			cmd_q <= (step < 12) ? sh[11] : ~cmd_q;
			sh <= {sh[10:0], 1'b0};
			// Frames collected top bit first
			if (step < 16) begin
				frame_a <= {frame_a[14:0], serial_out_a};
				frame_b <= {frame_b[14:0], serial_out_b};
			end
			act_q <= (step < 18);
			step <= (step < 18) ? step + 1 : -1;
		end
	end
endmodule : adcsc_host_model
`default_nettype wire

// *** adcsc_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module adcsc_ctrl_tb;
	logic clk = 1'b0; // Bench clock
	logic abort_seen = 1'b0; // Set once an abort pulse is seen
	logic rst_n, conv_trigger, single_output_pin, start, active;
	logic read_strobe, serial_cmd_in, serial_out_a, serial_out_b, serial_out_b_oe;
	logic conv_busy, conv_abort, pair_select, ref_power_down, special_read;
	logic analog_off, bias_off, powered_up;
	logic [11:0] adc_result_a, adc_result_b;
	logic [1:0] mux_select;
	logic [9:0] reference_dac_level, dv;
	logic [15:0] frame_a, frame_b;
	adcsc_pkg::adcsc_cmd_t word, w2; // Host word and a hand-built command
	int bad_count, n_tests, n;
	wire b_pin = serial_out_b_oe ? serial_out_b : 1'bz; // Line b as the host sees it

	// Auto pair cycling stays off: pseudo mux is used throughout
	adcsc_ctrl i_adcsc_ctrl (.clk, .rst_n, .clk_en(1'b1), .read_strobe, .conv_trigger,
		.serial_cmd_in, .channel_auto_select_pin(1'b0), .single_output_pin, .serial_out_a,
		.serial_out_b, .serial_out_b_oe, .adc_result_a, .adc_result_b, .conv_busy, .conv_abort,
		.mux_select, .pair_select, .reference_dac_level, .ref_power_down, .special_read,
		.analog_off, .bias_off, .powered_up);
	adcsc_host_model i_adcsc_host_model (.clk, .start, .word, .active, .frame_a, .frame_b,
		.read_strobe, .serial_cmd_in, .serial_out_a, .serial_out_b(b_pin));

	always #25 clk = ~clk;
	// Remember any abort pulse
	always @(posedge clk) if (conv_abort === 1'b1) abort_seen <= 1'b1;

	// Command word from its fields
	function automatic adcsc_pkg::adcsc_cmd_t cw(input logic [1:0] c, p, input logic [2:0] pd, a);
		cw = adcsc_pkg::CMD_RESET;
		cw.mux_channel_select = c;
		cw.feature_page_select = p;
		{cw.deep_sleep_enable, cw.nap_enable, cw.auto_sleep_enable} = pd;
		cw.action_code = a;
	endfunction : cw
	// Expected level read-back frame
	function automatic logic [15:0] rdf(input logic [9:0] v);
		rdf = {4'h0, v, 2'h0};
	endfunction : rdf
	// Expected result frame, dual-output layout
	function automatic logic [15:0] bfr(input logic [11:0] r);
		bfr = {2'h0, r, 2'h0};
	endfunction : bfr

	task automatic chk(input string nm, input logic [15:0] e, g);
		n_tests++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic close_out(input bit hung);
		if (hung) bad_count++;
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	// One host access, optionally with a conversion trigger beside it
	task automatic acc(input adcsc_pkg::adcsc_cmd_t w, input logic t);
		@(negedge clk);
		word <= w;
		start <= 1'b1;
		conv_trigger <= t;
		@(negedge clk);
		start <= 1'b0;
		conv_trigger <= 1'b0;
		repeat (2) @(negedge clk);
		for (n = 0; n < 40 && active === 1'b1; n++) @(negedge clk);
		if (n >= 40) close_out(1);
	endtask : acc
	// Bounded wait for the device to run again
	task automatic wait_up(input int lim);
		for (n = 0; n < lim && powered_up !== 1'b1; n++) @(negedge clk);
		if (n >= lim) close_out(1);
	endtask : wait_up

	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		word = '0;
		conv_trigger = 1'b0;
		single_output_pin = 1'b0;
		void'($urandom(16871));
		adc_result_a = 12'($urandom);
		adc_result_b = 12'($urandom);
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk("dac_reset", 16'h3ff, 16'(reference_dac_level));
		// Every mux code, both pair pages, idle action codes
		for (int i = 0; i < 8; i++) begin
			acc(cw(2'(i), (i < 4) ? 2'h0 : 2'h3, 3'h0, (i == 7) ? 3'h7 : 3'(2 * (i % 4))), 0);
			chk("mux", 16'(i % 4), 16'(mux_select));
			chk("pair", 16'(i >= 4), 16'(pair_select));
			chk("dac_idle", 16'h3ff, 16'(reference_dac_level));
		end
		// No-action codes on the feature page must not arm a level write
		acc(cw(2'h0, 2'h1, 3'h0, 3'(2 * ($urandom % 4))), 1'b0);
		acc(12'h000, 1'b0);
		chk("dac_noact", 16'h3ff, 16'(reference_dac_level));
		$display("test mux done");
		// Level write then read-back, with a conversion behind line b
		acc(cw(2'h2, 2'h0, 3'h0, 3'h0), 1'b1);
		dv = 10'($urandom);
		acc(cw(2'h2, 2'h1, 3'h0, adcsc_pkg::ACT_DAC_WR), 1'b0);
		acc({2'h0, dv}, 1'b0);
		chk("dac_wr", 16'(dv), 16'(reference_dac_level));
		chk("mux_wr", 16'h2, 16'(mux_select));
		acc(cw(2'h2, 2'h1, 3'h0, adcsc_pkg::ACT_DAC_RD), 1'b0);
		acc(12'($urandom), 1'b0);
		chk("dac_rd_a", rdf(dv), frame_a);
		chk("dac_rd_b", bfr(adc_result_b), frame_b);
		chk("mux_rd", 16'h2, 16'(mux_select));
		$display("test dac done");
		// Single output line
		single_output_pin = 1'b1;
		acc(cw(2'h2, 2'h0, 3'h0, 3'h0), 1'b0);
		chk("b_oe", 16'h0, 16'(serial_out_b_oe));
		chk("a_frame", bfr(adc_result_a), frame_a);
		acc(cw(2'h2, 2'h0, 3'h0, 3'h0), 1'b0);
		chk("a_frame_b", {2'h1, adc_result_b, 2'h0}, frame_a);
		single_output_pin = 1'b0;
		$display("test single done");
		// Nap entered in mid-conversion, held, then cleared
		w2 = cw(2'h1, 2'h1, 3'h2, 3'h0);
		w2.ref_power_down = 1'b1;
		w2.special_read = 1'b1;
		acc(w2, 1'b1);
		repeat (30) @(negedge clk);
		chk("nap", 16'h3, 16'({bias_off, abort_seen}));
		chk("nap_busy", 16'h0, 16'(conv_busy));
		chk("nap_up", 16'h0, 16'({powered_up, analog_off}));
		chk("nap_mux", 16'h1, 16'(mux_select));
		chk("nap_reg", 16'h3, 16'({ref_power_down, special_read}));
		// Clearing keeps the special read bit so only nap and reference change
		w2.nap_enable = 1'b0;
		w2.ref_power_down = 1'b0;
		acc(w2, 1'b0);
		chk("nap_wake", 16'h1, 16'(powered_up));
		chk("nap_bits", 16'h1, 16'({ref_power_down, special_read}));
		$display("test nap done");
		// Deep power-down and its long wake
		acc(cw(2'h1, 2'h1, 3'h4, 3'h0), 1'b0);
		chk("deep", 16'h3, 16'({analog_off, bias_off}));
		acc(cw(2'h1, 2'h1, 3'h0, 3'h0), 1'b0);
		chk("deep_hold", 16'h0, 16'(powered_up));
		wait_up(40);
		chk("deep_wake", 16'h1, 16'(n >= 8 && n <= adcsc_pkg::DEEP_WAKE_CYC + 2));
		$display("test deep done");
		// Auto-nap: sleeps after each conversion, trigger wakes
		acc(cw(2'h1, 2'h1, 3'h1, 3'h0), 1'b0);
		chk("anap_idle", 16'h1, 16'(powered_up));
		acc(cw(2'h1, 2'h0, 3'h0, 3'h0), 1'b1);
		repeat (5) @(negedge clk);
		chk("anap_in", 16'h1, 16'(bias_off));
		conv_trigger = 1'b1;
		@(negedge clk);
		conv_trigger = 1'b0;
		wait_up(6);
		chk("anap_conv", 16'h1, 16'(conv_busy));
		repeat (25) @(negedge clk);
		chk("anap_again", 16'h1, 16'(bias_off));
		acc(cw(2'h1, 2'h1, 3'h0, 3'h0), 1'b1);
		repeat (10) @(negedge clk);
		chk("anap_off", 16'h1, 16'(powered_up));
		$display("test auto-nap done");
		// Soft reset, then the interface at once
		acc(cw(2'h2, 2'h3, 3'h0, adcsc_pkg::ACT_RESET), 1'b0);
		chk("srst_dac", 16'h3ff, 16'(reference_dac_level));
		chk("srst_mux", 16'h0, 16'({mux_select, pair_select}));
		acc(cw(2'h3, 2'h0, 3'h0, 3'h0), 1'b0);
		chk("srst_ready", 16'h3, 16'(mux_select));
		$display("test soft reset done");
		close_out(0);
	end
endmodule : adcsc_ctrl_tb
`default_nettype wire
